// ===== core/spi_global_control_regmap.sv
// Decided for this implementation: register access over AXI4-Lite.
`timescale 1ns/100ps
`include "spi_regmap_defs.svh"
// What this block does
// - module held in reset while reset bit is 0, released at 1
// - format select picks one of four formats; target role uses format 0
// - delay register applies in controller role only
// - reserved bits read zero, writes to them ignored
// - registers decoded at fixed byte offsets 0h to 64h
// - enable cleared zeroes tx data, flags, rx buffer; rx empty stays set
// - sleep gates internal clocks; register accesses still clocked
// - wrap test with data pins functional loops data, idles clock pin
module spi_global_control_regmap (
    input wire logic aclk, // bus clock
    input wire logic aresetn, // sync reset
    input wire spi_regmap_pkg::axi_req_type axi_in, // bus request
    output spi_regmap_pkg::axi_rsp_type axi_out, // bus answer
    input wire logic [`EV_W-1:0] events, // engine event pulses
    input wire logic rx_valid, // received char pulse
    input wire logic [15:0] rx_data, // received char
    input wire logic [`PIN_W-1:0] pin_in, // pin levels
    input wire logic [`PIN_W-1:0] func_out, // engine pin drive
    input wire logic [`PIN_W-1:0] func_oe, // engine pin enable
    output logic [`PIN_W-1:0] pin_out, // pin drive value
    output logic [`PIN_W-1:0] pin_oe, // pin drive enable
    output spi_regmap_pkg::ctrl_type ctrl, // engine controls
    output logic core_clk_en, // internal clock gate
    output logic irq // level interrupt
);
    import spi_regmap_pkg::*;

    // ----------------------------------------
    // state
    // ----------------------------------------
    typedef struct packed {
        logic aw_held;
        logic [`AW-1:0] awaddr;
        logic w_held;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic rvalid;
        logic [31:0] rdata;
        logic grst;
        logic [31:0] cfg;
        logic [31:0] int_en;
        logic [31:0] int_lvl;
        logic [`EV_W-1:0] flags;
        logic [`PIN_W-1:0] pfun;
        logic [`PIN_W-1:0] pdir;
        logic [`PIN_W-1:0] pout;
        logic [31:0] txd0;
        logic [31:0] txd1;
        logic tx_load;
        logic [15:0] rxd;
        logic rx_empty;
        logic [31:0] delays;
        logic [31:0] idle_def;
        logic [3:0][31:0] fmt;
    } state_type;

    state_type s_q;
    state_type s_d;
    logic [`PIN_W-1:0] drv_val;
    logic wrap_on;
    logic [1:0] fsel;

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    // byte lane merge of a write onto an old word
    function automatic logic [31:0] merge(
        input logic [31:0] old,
        input logic [31:0] nw,
        input logic [3:0] be
    );
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[8*i +: 8] = nw[8*i +: 8];
            end
        end
        return r;
    endfunction : merge

    // lowest pending enabled event, plus one; zero when none
    function automatic logic [31:0] vec_of(input logic [`EV_W-1:0] p);
        logic [31:0] v;
        v = `ZERO32;
        for (int i = `EV_W - 1; i >= 0; i--) begin
            if (p[i]) begin
                v = 32'(i + 1);
            end
        end
        return v;
    endfunction : vec_of

    // the four format words form one aligned run; both decodes share this test
    function automatic logic is_fmt(input logic [`AW-1:0] a);
        return (a >= `OFS_FMT0) && (a <= `OFS_FMT3) && (a[1:0] == 2'h0);
    endfunction : is_fmt

    // word number inside the format run
    function automatic logic [1:0] fmt_idx(input logic [`AW-1:0] a);
        return a[`FMT_IDX_LO +: 2];
    endfunction : fmt_idx

    // state of a register block that has just been reset
    function automatic state_type cleared(input state_type st);
        state_type r;
        r = st;
        r.cfg = `ZERO32;
        r.int_en = `ZERO32;
        r.int_lvl = `ZERO32;
        r.flags = '0;
        r.pfun = '0;
        r.pdir = '0;
        r.pout = '0;
        r.txd0 = `ZERO32;
        r.txd1 = `ZERO32;
        r.tx_load = 1'b0;
        r.rxd = '0;
        r.rx_empty = 1'b1;
        r.delays = `ZERO32;
        r.idle_def = `ZERO32;
        r.fmt = '0;
        return r;
    endfunction : cleared

    // ----------------------------------------
    // pin routing and derived controls
    // ----------------------------------------
    // target role only ever uses the first format
    assign fsel = s_q.cfg[`CFG_ROLE] ? s_q.txd1[`FSEL_LO +: 2] : 2'h0;
    // wrap needs both data pins in serial function, otherwise pins behave normally
    assign wrap_on = s_q.cfg[`CFG_WRAP] & s_q.pfun[`PIN_SIMO] & s_q.pfun[`PIN_SOMI];

    // functional pins follow the engine, others follow gpio registers
    always_comb begin
        for (int i = 0; i < `PIN_W; i++) begin
            pin_out[i] = s_q.pfun[i] ? func_out[i] : s_q.pout[i];
            pin_oe[i] = s_q.pfun[i] ? func_oe[i] : s_q.pdir[i];
        end
        // wrap test: data pins float, clock rests at its idle level
        if (wrap_on) begin
            pin_oe[`PIN_SIMO] = 1'b0;
            pin_oe[`PIN_SOMI] = 1'b0;
            pin_out[`PIN_CLK] = s_q.fmt[fsel][`FMT_POL];
            pin_oe[`PIN_CLK] = s_q.pfun[`PIN_CLK];
        end
    end

    // input view shows what is driven on output pins
    always_comb begin
        for (int i = 0; i < `PIN_W; i++) begin
            drv_val[i] = pin_oe[i] ? pin_out[i] : pin_in[i];
        end
    end

    // engine controls
    always_comb begin
        ctrl.module_rst_n = s_q.grst;
        ctrl.enable = s_q.cfg[`CFG_EN];
        ctrl.master = s_q.cfg[`CFG_ROLE];
        ctrl.clock_source_mode = s_q.cfg[`CFG_CLOCK_SOURCE_MODE];
        ctrl.local_sleep = s_q.cfg[`CFG_SLEEP];
        ctrl.wrap_active = wrap_on;
        ctrl.tx_load = s_q.tx_load;
        ctrl.tx_data = s_q.txd1[15:0];
        ctrl.format_select = fsel;
        ctrl.char_format = s_q.fmt[fsel];
        // delays mean nothing to a target, so it sees zero
        ctrl.delays = s_q.cfg[`CFG_ROLE] ? s_q.delays : `ZERO32;
        ctrl.idle_level = s_q.idle_def;
        ctrl.int_level = s_q.int_lvl;
        // dma requests have their own enable, set by software after the block is on
        ctrl.dma_request_enable = s_q.int_en[`DMA_REQ_BIT];
    end

    // sleep stops internal logic, but any bus access wakes it for itself
    assign core_clk_en = ~s_q.cfg[`CFG_SLEEP] | axi_in.awvalid | axi_in.wvalid
        | axi_in.arvalid | s_q.aw_held | s_q.w_held | s_q.bvalid | s_q.rvalid;

    // level output: stays high until the flag is cleared or masked
    assign irq = |(s_q.flags & s_q.int_en[`EV_W-1:0]);

    // ----------------------------------------
    // bus handshakes
    // ----------------------------------------
    // one write and one read at a time; a pending answer blocks new requests
    always_comb begin
        axi_out.awready = ~s_q.aw_held & ~s_q.bvalid;
        axi_out.wready = ~s_q.w_held & ~s_q.bvalid;
        axi_out.bvalid = s_q.bvalid;
        axi_out.bresp = `RESP_OK;
        axi_out.arready = ~s_q.rvalid;
        axi_out.rvalid = s_q.rvalid;
        axi_out.rdata = s_q.rdata;
        axi_out.rresp = `RESP_OK;
    end

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        logic [31:0] wv;
        logic [31:0] w1;
        logic [31:0] rd;
        logic [`EV_W-1:0] clr;
        wv = `ZERO32;
        w1 = `ZERO32;
        rd = `ZERO32;
        clr = '0;
        s_d = s_q;
        s_d.tx_load = 1'b0;

        // address and data may arrive in either order
        if (axi_in.awvalid && axi_out.awready) begin
            s_d.aw_held = 1'b1;
            s_d.awaddr = axi_in.awaddr;
        end
        if (axi_in.wvalid && axi_out.wready) begin
            s_d.w_held = 1'b1;
            s_d.wdata = axi_in.wdata;
            s_d.wstrb = axi_in.wstrb;
        end

        // write commits one cycle after both halves are held
        if (s_q.aw_held && s_q.w_held) begin
            s_d.aw_held = 1'b0;
            s_d.w_held = 1'b0;
            s_d.bvalid = 1'b1;
            w1 = merge(`ZERO32, s_q.wdata, s_q.wstrb);
            case (s_q.awaddr)
                `OFS_GRST: begin
                    // only bit 0 is kept, the rest reads back as zero
                    wv = merge({31'h0, s_q.grst}, s_q.wdata, s_q.wstrb);
                    s_d.grst = wv[`GRST_BIT];
                end
                `OFS_GCFG: begin
                    wv = merge(s_q.cfg, s_q.wdata, s_q.wstrb);
                    s_d.cfg = wv & `CFG_MASK;
                end
                `OFS_INTEN: s_d.int_en = merge(s_q.int_en, s_q.wdata, s_q.wstrb);
                `OFS_INTLVL: s_d.int_lvl = merge(s_q.int_lvl, s_q.wdata, s_q.wstrb);
                `OFS_FLAGS: clr = w1[`EV_W-1:0];
                `OFS_PFUN: begin
                    wv = merge({16'h0, s_q.pfun}, s_q.wdata, s_q.wstrb);
                    s_d.pfun = wv[`PIN_W-1:0];
                end
                `OFS_PDIR: begin
                    wv = merge({16'h0, s_q.pdir}, s_q.wdata, s_q.wstrb);
                    s_d.pdir = wv[`PIN_W-1:0];
                end
                `OFS_POUT: begin
                    wv = merge({16'h0, s_q.pout}, s_q.wdata, s_q.wstrb);
                    s_d.pout = wv[`PIN_W-1:0];
                end
                // set and clear ports avoid read-modify-write races
                `OFS_PSET: s_d.pout = s_q.pout | w1[`PIN_W-1:0];
                `OFS_PCLR: s_d.pout = s_q.pout & ~w1[`PIN_W-1:0];
                `OFS_TXD0: begin
                    wv = merge(s_q.txd0, s_q.wdata, s_q.wstrb);
                    s_d.txd0 = wv & `TXD_MASK;
                    s_d.txd1 = (s_q.txd1 & ~`TXD_MASK) | (wv & `TXD_MASK);
                    s_d.tx_load = 1'b1;
                end
                // either data word loads the engine; the mirror keeps the low 16 bits of both views equal
                `OFS_TXD1: begin
                    s_d.txd1 = merge(s_q.txd1, s_q.wdata, s_q.wstrb);
                    s_d.txd0 = s_d.txd1 & `TXD_MASK;
                    s_d.tx_load = 1'b1;
                end
                `OFS_DELAY: s_d.delays = merge(s_q.delays, s_q.wdata, s_q.wstrb);
                `OFS_IDLE: s_d.idle_def = merge(s_q.idle_def, s_q.wdata, s_q.wstrb);
                default: begin
                    // format words sit in one aligned run of four
                    if (is_fmt(s_q.awaddr)) begin
                        s_d.fmt[fmt_idx(s_q.awaddr)] =
                            merge(s_q.fmt[fmt_idx(s_q.awaddr)], s_q.wdata, s_q.wstrb);
                    end
                    // any other offset is read-only or unassigned and the write is dropped
                end
            endcase
        end
        // the answer stands until the master takes it
        if (s_q.bvalid && axi_in.bready) begin
            s_d.bvalid = 1'b0;
        end

        // read: data captured at address acceptance
        if (axi_in.arvalid && axi_out.arready) begin
            case (axi_in.araddr)
                `OFS_GRST: rd = {31'h0, s_q.grst};
                `OFS_GCFG: rd = s_q.cfg;
                `OFS_INTEN: rd = s_q.int_en;
                `OFS_INTLVL: rd = s_q.int_lvl;
                `OFS_FLAGS: rd = 32'(s_q.flags);
                `OFS_PFUN: rd = 32'(s_q.pfun);
                `OFS_PDIR: rd = 32'(s_q.pdir);
                `OFS_PIN: rd = 32'(drv_val);
                `OFS_POUT: rd = 32'(s_q.pout);
                `OFS_PSET: rd = 32'(s_q.pout);
                `OFS_PCLR: rd = 32'(s_q.pout);
                `OFS_TXD0: rd = s_q.txd0;
                `OFS_TXD1: rd = s_q.txd1;
                `OFS_RXB: begin
                    rd = {s_q.rx_empty, 15'h0, s_q.rxd};
                    s_d.rx_empty = 1'b1; // reading consumes the char
                end
                // debug view has no read side effect
                `OFS_RXDBG: rd = {s_q.rx_empty, 15'h0, s_q.rxd};
                `OFS_DELAY: rd = s_q.delays;
                `OFS_IDLE: rd = s_q.idle_def;
                // vector reads have no side effect; flags are cleared by writing
                `OFS_VEC: rd = vec_of(s_q.flags & s_q.int_en[`EV_W-1:0]);
                default: begin
                    rd = `ZERO32;
                    if (is_fmt(axi_in.araddr)) begin
                        rd = s_q.fmt[fmt_idx(axi_in.araddr)];
                    end
                end
            endcase
            // read data is registered so it stands until taken
            s_d.rvalid = 1'b1;
            s_d.rdata = rd;
        end else if (s_q.rvalid && axi_in.rready) begin
            s_d.rvalid = 1'b0;
        end

        // sticky events: a set in the clearing cycle survives
        s_d.flags = (s_q.flags & ~clr) | events;
        // new data beats a same-cycle read that sets the empty flag
        if (rx_valid) begin
            s_d.rxd = rx_data;
            s_d.rx_empty = 1'b0;
        end

        // disabled block keeps no stale data or flags
        if (!s_d.cfg[`CFG_EN]) begin
            s_d.txd0 = s_d.txd0 & ~`TXD_MASK;
            s_d.txd1 = s_d.txd1 & ~`TXD_MASK;
            s_d.flags = '0;
            s_d.rxd = '0;
            s_d.rx_empty = 1'b1;
            s_d.tx_load = 1'b0;
        end

        // while held in reset only the reset word itself is writable
        if (!s_q.grst) begin
            s_d = cleared(s_d);
        end
    end

    // ----------------------------------------
    // registers
    // ----------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            // an empty receive buffer is the idle state, so its flag starts set
            s_q <= '0;
            s_q.rx_empty <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end
endmodule : spi_global_control_regmap

// ===== core/spi_regmap_defs.svh
`ifndef SPI_REGMAP_DEFS_SVH
`define SPI_REGMAP_DEFS_SVH
// ----------------------------------------
// widths
// ----------------------------------------
`define AW 7
`define EV_W 8
`define PIN_W 16
// ----------------------------------------
// byte offsets
// ----------------------------------------
`define OFS_GRST 7'h00
`define OFS_GCFG 7'h04
`define OFS_INTEN 7'h08
`define OFS_INTLVL 7'h0c
`define OFS_FLAGS 7'h10
`define OFS_PFUN 7'h14
`define OFS_PDIR 7'h18
`define OFS_PIN 7'h1c
`define OFS_POUT 7'h20
`define OFS_PSET 7'h24
`define OFS_PCLR 7'h28
`define OFS_TXD0 7'h38
`define OFS_TXD1 7'h3c
`define OFS_RXB 7'h40
`define OFS_RXDBG 7'h44
`define OFS_DELAY 7'h48
`define OFS_IDLE 7'h4c
`define OFS_FMT0 7'h50
`define OFS_FMT3 7'h5c
`define OFS_VEC 7'h64
// ----------------------------------------
// fields and masks
// ----------------------------------------
`define GRST_BIT 0
`define CFG_ROLE 0
`define CFG_CLOCK_SOURCE_MODE 1
`define CFG_SLEEP 8
`define CFG_WRAP 16
`define CFG_EN 24
`define CFG_MASK 32'h0101_0103
`define GRST_MASK 32'h0000_0001
`define TXD_MASK 32'h0000_ffff
`define FSEL_LO 24
`define FMT_POL 17
`define DMA_REQ_BIT 24
`define FMT_IDX_LO 2
`define RXE_BIT 31
`define PIN_CLK 0
`define PIN_SIMO 1
`define PIN_SOMI 2
`define ZERO32 32'h0000_0000
`define RESP_OK 2'h0
`endif

// ===== core/spi_regmap_pkg.sv
`include "spi_regmap_defs.svh"
package spi_regmap_pkg;
    // ----------------------------------------
    // bus carriers
    // ----------------------------------------
    typedef struct packed {
        logic awvalid;
        logic [`AW-1:0] awaddr;
        logic wvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bready;
        logic arvalid;
        logic [`AW-1:0] araddr;
        logic rready;
    } axi_req_type;
    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } axi_rsp_type;
    // ----------------------------------------
    // controls toward the serial engine
    // ----------------------------------------
    typedef struct packed {
        logic module_rst_n;
        logic enable;
        logic master;
        logic clock_source_mode;
        logic local_sleep;
        logic wrap_active;
        logic tx_load;
        logic [15:0] tx_data;
        logic [1:0] format_select;
        logic [31:0] char_format;
        logic [31:0] delays;
        logic [31:0] idle_level;
        logic [31:0] int_level;
        logic dma_request_enable;
    } ctrl_type;
endpackage : spi_regmap_pkg

// ===== sim/spi_global_control_regmap_asserts.sv
`timescale 1ns/100ps
`include "spi_regmap_defs.svh"
module spi_global_control_regmap_asserts (
    input wire logic aclk, // bus clock
    input wire logic aresetn, // sync reset
    input wire spi_regmap_pkg::axi_req_type axi_in, // bus request
    input wire spi_regmap_pkg::axi_rsp_type axi_out, // bus answer
    input wire logic [`PIN_W-1:0] pin_oe, // pin enables
    input wire spi_regmap_pkg::ctrl_type ctrl, // engine controls
    input wire logic core_clk_en // clock gate
);
    import spi_regmap_pkg::*;
    // ----------------------------------------
    // properties
    // ----------------------------------------
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // one cycle of slack: the reset word write lands before the clear
    property p_rst_hold;
        !ctrl.module_rst_n [*2] |-> !ctrl.enable && !ctrl.master;
    endproperty
    property p_fmt_target;
        !ctrl.master |-> ctrl.format_select == 2'h0;
    endproperty
    property p_delay_target;
        !ctrl.master |-> ctrl.delays == `ZERO32;
    endproperty
    property p_tx_clear;
        !ctrl.enable [*2] |-> ctrl.tx_data == 16'h0000 && !ctrl.tx_load;
    endproperty
    property p_sleep_access;
        ctrl.local_sleep && (axi_in.arvalid || axi_in.awvalid) |-> core_clk_en;
    endproperty
    property p_wrap_quiet;
        ctrl.wrap_active |-> !pin_oe[`PIN_SIMO] && !pin_oe[`PIN_SOMI];
    endproperty
    property p_wr_resp;
        axi_in.awvalid && axi_out.awready && axi_in.wvalid && axi_out.wready
            |-> ##1 !axi_out.bvalid ##1 axi_out.bvalid && axi_out.bresp == `RESP_OK;
    endproperty
    property p_rd_resp;
        axi_in.arvalid && axi_out.arready |=> axi_out.rvalid && axi_out.rresp == `RESP_OK;
    endproperty
    property p_b_busy;
        axi_out.bvalid |-> !axi_out.awready && !axi_out.wready;
    endproperty
    property p_r_busy;
        axi_out.rvalid |-> !axi_out.arready;
    endproperty
    a_rst_hold: assert property (p_rst_hold) else $error("config live in reset");
    a_fmt_target: assert property (p_fmt_target) else $error("format select in target");
    a_delay_target: assert property (p_delay_target) else $error("delays in target");
    a_tx_clear: assert property (p_tx_clear) else $error("tx data kept while off");
    a_sleep_access: assert property (p_sleep_access) else $error("access not clocked");
    a_wrap_quiet: assert property (p_wrap_quiet) else $error("data pin driven in wrap");
    a_wr_resp: assert property (p_wr_resp) else $error("write answer late");
    a_rd_resp: assert property (p_rd_resp) else $error("read answer late");
    a_b_busy: assert property (p_b_busy) else $error("write taken while answering");
    a_r_busy: assert property (p_r_busy) else $error("read taken while answering");
    c_write: cover property (axi_out.bvalid && axi_in.bready);
    c_read: cover property (axi_out.rvalid && axi_in.rready);
    c_wrap: cover property (ctrl.wrap_active);
endmodule : spi_global_control_regmap_asserts

// ===== sim/tb_spi_global_control_regmap.sv
`timescale 1ns/100ps
`include "spi_regmap_defs.svh"
module tb_spi_global_control_regmap;
    import spi_regmap_pkg::*;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    axi_req_type req = '0;
    axi_rsp_type rsp;
    logic [7:0] events = 8'h00;
    logic rx_valid = 1'b0;
    logic [15:0] rx_data = 16'h0000;
    logic [15:0] pin_in = 16'h0000;
    logic [15:0] func_out = 16'h0000;
    logic [15:0] func_oe = 16'hffff;
    logic [15:0] pin_out, pin_oe;
    ctrl_type ctrl;
    logic core_clk_en, irq;
    logic [31:0] seed = 32'h0000_0058;
    logic [31:0] rd, dly;
    logic [31:0] fmt [4];
    logic [6:0] holes [6] = '{7'h2c, 7'h30, 7'h34, 7'h60, 7'h68, 7'h7c};
    int miscompares = 0;
    int num_checks = 0;
    int cycles = 0;
    always #5 aclk = ~aclk;
    spi_global_control_regmap dut (.aclk(aclk), .aresetn(aresetn), .axi_in(req),
        .axi_out(rsp), .events(events), .rx_valid(rx_valid), .rx_data(rx_data),
        .pin_in(pin_in), .func_out(func_out), .func_oe(func_oe), .pin_out(pin_out),
        .pin_oe(pin_oe), .ctrl(ctrl), .core_clk_en(core_clk_en), .irq(irq));
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    // lowest pending index plus one, zero when none
    function automatic logic [31:0] exp_vec(input logic [7:0] f);
        for (int i = 0; i < 8; i++) if (f[i]) return 32'(i + 1);
        return `ZERO32;
    endfunction : exp_vec
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic final_report();
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : final_report
    // address and data offered together, each dropped once taken
    task automatic wr(input logic [6:0] a, input logic [31:0] d);
        @(posedge aclk);
        req.awvalid <= 1'b1;
        req.awaddr <= a;
        req.wvalid <= 1'b1;
        req.wdata <= d;
        req.wstrb <= 4'hf;
        req.bready <= 1'b1;
        forever begin
            @(posedge aclk);
            if (req.awvalid && rsp.awready) req.awvalid <= 1'b0;
            if (req.wvalid && rsp.wready) req.wvalid <= 1'b0;
            if (rsp.bvalid) begin
                req.bready <= 1'b0;
                break;
            end
        end
        #1;
    endtask : wr
    task automatic rchk(input logic [6:0] a, input logic [31:0] exp);
        @(posedge aclk);
        req.arvalid <= 1'b1;
        req.araddr <= a;
        req.rready <= 1'b1;
        forever begin
            @(posedge aclk);
            if (req.arvalid && rsp.arready) req.arvalid <= 1'b0;
            if (rsp.rvalid) begin
                rd = rsp.rdata;
                req.rready <= 1'b0;
                break;
            end
        end
        #1;
        chk(rd, exp);
    endtask : rchk
    // hang guard, well above the planned run
    always @(posedge aclk) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            final_report();
        end
    end
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        pin_in <= seed[15:0];
        func_out <= seed[31:16];
        chk(32'(ctrl.module_rst_n), `ZERO32);
        wr(`OFS_GCFG, 32'hffff_ffff);
        rchk(`OFS_GCFG, `ZERO32);
        wr(`OFS_GRST, `ZERO32);
        wr(`OFS_GRST, 32'hffff_ffff);
        rchk(`OFS_GRST, `GRST_MASK);
        wr(`OFS_GCFG, 32'hffff_ffff);
        rchk(`OFS_GCFG, `CFG_MASK);
        // bring-up: role, pins, formats, delays, interrupts, then enable and dma
        wr(`OFS_GCFG, 32'h0000_0003);
        chk(32'(ctrl.clock_source_mode), 32'h0000_0001);
        wr(`OFS_PFUN, 32'h0000_0007);
        for (int i = 0; i < 4; i++) begin
            seed = lfsr(seed);
            fmt[i] = seed;
            wr(`OFS_FMT0 + 7'(4 * i), seed);
        end
        seed = lfsr(seed);
        dly = seed;
        wr(`OFS_DELAY, dly);
        chk(ctrl.delays, dly);
        seed = lfsr(seed);
        wr(`OFS_INTLVL, seed);
        chk(ctrl.int_level, seed);
        wr(`OFS_GCFG, 32'h0100_0001);
        wr(`OFS_INTEN, 32'h0100_0000);
        chk(32'(ctrl.dma_request_enable), 32'h0000_0001);
        foreach (holes[i]) begin
            wr(holes[i], 32'hffff_ffff);
            rchk(holes[i], `ZERO32);
        end
        for (int i = 0; i < 4; i++) rchk(`OFS_FMT0 + 7'(4 * i), fmt[i]);
        rchk(`OFS_DELAY, dly);
        // serial pins show what the engine drives, the rest show the pin
        rchk(`OFS_PIN, {16'h0000, (pin_in & 16'hfff8) | (func_out & 16'h0007)});
        seed = lfsr(seed);
        wr(`OFS_IDLE, seed);
        rchk(`OFS_IDLE, seed);
        chk(ctrl.idle_level, seed);
        wr(`OFS_POUT, 32'h0000_0ff0);
        wr(`OFS_PSET, 32'h0000_f000);
        wr(`OFS_PCLR, 32'h0000_00f0);
        rchk(`OFS_POUT, 32'h0000_ff00);
        chk(32'(pin_out & 16'hfff8), 32'h0000_ff00);
        for (int s = 0; s < 4; s++) begin
            seed = lfsr(seed);
            wr(`OFS_TXD1, {6'h00, 2'(s), 8'h00, seed[15:0]});
            chk(32'(ctrl.format_select), 32'(s));
            chk(ctrl.char_format, fmt[s]);
            chk(32'(ctrl.tx_data), 32'(seed[15:0]));
        end
        wr(`OFS_GCFG, 32'h0100_0000);
        chk(32'(ctrl.format_select), `ZERO32);
        chk(ctrl.char_format, fmt[0]);
        chk(ctrl.delays, `ZERO32);
        // sticky flags, mask, vector and clear
        wr(`OFS_INTEN, 32'h0000_00ff);
        seed = lfsr(seed);
        @(posedge aclk);
        events <= seed[7:0] | 8'h80;
        @(posedge aclk);
        events <= 8'h00;
        #1;
        chk(32'(irq), 32'h0000_0001);
        rchk(`OFS_FLAGS, {24'h0, seed[7:0] | 8'h80});
        rchk(`OFS_VEC, exp_vec(seed[7:0] | 8'h80));
        wr(`OFS_INTEN, `ZERO32);
        chk(32'(irq), `ZERO32);
        wr(`OFS_INTEN, 32'h0000_0080);
        chk(32'(irq), 32'h0000_0001);
        wr(`OFS_FLAGS, 32'h0000_00ff);
        chk(32'(irq), `ZERO32);
        rchk(`OFS_FLAGS, `ZERO32);
        // received char, then disable clears the data path
        @(posedge aclk);
        rx_valid <= 1'b1;
        rx_data <= seed[31:16];
        @(posedge aclk);
        rx_valid <= 1'b0;
        rchk(`OFS_RXDBG, {16'h0000, seed[31:16]});
        rchk(`OFS_RXB, {16'h0000, seed[31:16]});
        wr(`OFS_TXD0, 32'h0000_1234);
        wr(`OFS_GCFG, `ZERO32);
        chk(32'(ctrl.tx_data), `ZERO32);
        rchk(`OFS_TXD0, `ZERO32);
        rchk(`OFS_RXB, 32'h8000_0000);
        wr(`OFS_GCFG, 32'h0000_0100);
        chk(32'(core_clk_en), `ZERO32);
        rchk(`OFS_GCFG, 32'h0000_0100);
        wr(`OFS_PFUN, 32'h0000_0006);
        wr(`OFS_GCFG, 32'h0101_0001);
        chk(32'(ctrl.wrap_active), 32'h0000_0001);
        chk(32'(pin_oe[2:0]), `ZERO32);
        chk(32'(pin_out[`PIN_CLK]), 32'(fmt[3][`FMT_POL]));
        wr(`OFS_GRST, `ZERO32);
        rchk(`OFS_GCFG, `ZERO32);
        chk(32'(ctrl.module_rst_n), `ZERO32);
        final_report();
    end
endmodule : tb_spi_global_control_regmap
bind spi_global_control_regmap spi_global_control_regmap_asserts u_chk (.aclk(aclk),
    .aresetn(aresetn), .axi_in(axi_in), .axi_out(axi_out), .pin_oe(pin_oe),
    .ctrl(ctrl), .core_clk_en(core_clk_en));
